// [src/host_port_interrupt_event_csr.sv]
// host-port interrupt event, mask and port control register space
`timescale 1ns/1ps
`default_nettype none
module host_port_interrupt_event_csr
   import hp_event_pkg::*;
#(
   parameter int CHANNELS = DSP_CHANNELS
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire reg_req_s req_in,
   input wire logic [ADDR_W-1:0] mem_base_in,
   input wire logic [ADDR_W-1:0] io_base_in,
   input wire logic [CHANNELS-1:0] dsp_channel_interrupt_in,
   input wire logic general_interrupt_input_in,
   input wire logic general_port_error_in,
   input wire logic [1:0] gpio_pin_in,
   input wire pin_cfg_s pin_cfg_in,
   input wire logic [CHANNELS-1:0] dsp_port_error_in,
   input wire logic [CHANNELS-1:0] dsp_present_in,
   output logic ack_out,
   output logic [DATA_W-1:0] rdata_out,
   output logic irq_out,
   output logic [CHANNELS-1:0] dsp_reset_out,
   output logic [CHANNELS-1:0] port_wide_out
);

   function automatic logic window_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
      window_hit = (a[ADDR_W-1:WIN_LSB] == base[ADDR_W-1:WIN_LSB]);
   endfunction : window_hit

   function automatic logic [DATA_W-1:0] w1_strobe(input logic hit, input logic [DATA_W-1:0] d,
                                                   input logic [DATA_W-1:0] keep);
      w1_strobe = hit ? (d & keep) : '0;
   endfunction : w1_strobe

   logic hit;
   logic [WIN_LSB-1:0] offset;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] event_q;
   logic [DATA_W-1:0] event_view;
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] hw_set;
   logic [DATA_W-1:0] sw_set;
   logic [DATA_W-1:0] sw_clr;
   logic [DATA_W-1:0] event_d;
   logic [CHANNELS-1:0] dsp_prev_q;
   logic gp_int_prev_q;
   logic gp_err_prev_q;
   logic [1:0] pin_prev_q;
   logic [1:0] pin_edge;
   logic [CHANNELS-1:0] err_q;
   logic [CHANNELS-1:0] err_clr;
   logic [CHANNELS-1:0] dsp_reset_q;
   logic [CHANNELS-1:0] port_wide_q;
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] err_wr;
   logic [DATA_W-1:0] masked_view;

   // both spaces share one decoder; the window is 32 bytes in either
   assign hit = req_in.valid &&
                (req_in.io_space ? window_hit(req_in.addr, io_base_in)
                                 : window_hit(req_in.addr, mem_base_in));
   assign offset = req_in.addr[WIN_LSB-1:0];
   assign wr = hit && req_in.write;
   assign rd = hit && !req_in.write;

   // pin edge polarity follows the configured event type
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_edge[i] = pin_cfg_in.falling[i] ? (pin_prev_q[i] && !gpio_pin_in[i])
                                             : (!pin_prev_q[i] && gpio_pin_in[i]);
      end
   end

   always_comb begin
      hw_set = '0;
      hw_set[CHANNELS-1:0] = dsp_channel_interrupt_in & ~dsp_prev_q;
      hw_set[BIT_GP_INT] = general_interrupt_input_in && !gp_int_prev_q;
      hw_set[BIT_PIN2] = pin_cfg_in.fn_select[0] && pin_edge[0];
      hw_set[BIT_PIN3] = pin_cfg_in.fn_select[1] && pin_edge[1];
      hw_set[BIT_GP_ERR] = general_port_error_in && !gp_err_prev_q;
   end

   assign sw_set = w1_strobe(wr && offset == OFF_EVENT_SET, req_in.wdata, EVENT_SW_BITS);
   assign sw_clr = w1_strobe(wr && offset == OFF_EVENT_CLR, req_in.wdata, EVENT_SW_BITS);
   // hardware set applied after the clear so a coincident edge survives
   assign event_d = ((event_q & ~sw_clr) | sw_set | hw_set) & EVENT_SW_BITS;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dsp_prev_q <= '0;
         gp_int_prev_q <= 1'b0;
         gp_err_prev_q <= 1'b0;
         pin_prev_q <= '0;
      end else if (ce_in) begin
         dsp_prev_q <= dsp_channel_interrupt_in;
         gp_int_prev_q <= general_interrupt_input_in;
         gp_err_prev_q <= general_port_error_in;
         pin_prev_q <= gpio_pin_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         event_q <= RESET_VALUE;
      end else if (ce_in) begin
         event_q <= event_d;
      end
   end

   // bit 30 is a live summary, so it never lives in the sticky register
   always_comb begin
      event_view = event_q;
      event_view[BIT_PORT_ERR_SUM] = |err_q;
   end

   // the clear alias read shows only what could raise the interrupt
   assign masked_view = event_view & mask_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mask_q <= RESET_VALUE;
      end else if (ce_in) begin
         mask_q <= (mask_q | w1_strobe(wr && offset == OFF_MASK_SET, req_in.wdata, MASK_BITS))
                   & ~w1_strobe(wr && offset == OFF_MASK_CLR, req_in.wdata, MASK_BITS);
      end
   end

   // port error report: sticky per channel, write one to clear, error wins
   assign err_wr = w1_strobe(wr && offset == OFF_ERR_REPORT, req_in.wdata, '1);
   assign err_clr = err_wr[CHANNELS-1:0];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_q <= '0;
      end else if (ce_in) begin
         err_q <= (err_q & ~err_clr) | dsp_port_error_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dsp_reset_q <= '0;
         port_wide_q <= '0;
      end else if (ce_in) begin
         if (wr && offset == OFF_DSP_RESET) begin
            dsp_reset_q <= req_in.wdata[CHANNELS-1:0];
         end
         if (wr && offset == OFF_DATA_WIDTH) begin
            port_wide_q <= req_in.wdata[CHANNELS-1:0];
         end
      end
   end

   always_comb begin
      read_mux = '0;
      case (offset)
         OFF_EVENT_SET: begin
            read_mux = event_view;
         end
         OFF_EVENT_CLR: begin
            read_mux = event_view & mask_q;
         end
         OFF_MASK_SET, OFF_MASK_CLR: begin
            read_mux = mask_q;
         end
         OFF_ERR_REPORT: begin
            read_mux[CHANNELS-1:0] = err_q;
         end
         OFF_DSP_RESET: begin
            read_mux[CHANNELS-1:0] = dsp_reset_q;
            read_mux[IMPL_LSB +: CHANNELS] = dsp_present_in;
         end
         OFF_DATA_WIDTH: begin
            read_mux[CHANNELS-1:0] = port_wide_q;
         end
         default: begin
            read_mux = '0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_out <= 1'b0;
         rdata_out <= RESET_VALUE;
      end else if (ce_in) begin
         ack_out <= hit;
         if (rd) begin
            rdata_out <= read_mux;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else if (ce_in) begin
         irq_out <= mask_q[BIT_GLOBAL_EN] && |(event_view & mask_q & ~EVENT_RSVD);
      end
   end

   assign dsp_reset_out = dsp_reset_q;
   assign port_wide_out = port_wide_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_edge_sets_event: assert property (ce_in && dsp_channel_interrupt_in[0] && !dsp_prev_q[0]
      |=> event_q[0]) else $error("dsp edge did not set event");
   a_event_stays_set: assert property (ce_in && event_q[1] && !sw_clr[1] |=> event_q[1])
      else $error("event bit fell without clear");
   a_clear_only_write: assert property (event_q[2] ##1 !event_q[2] |-> $past(sw_clr[2]))
      else $error("event bit cleared without clear write");
   a_set_alias_sets: assert property (ce_in && sw_set[BIT_GP_INT] |=> event_q[BIT_GP_INT])
      else $error("set alias write ignored");
   a_set_beats_clear: assert property (ce_in && hw_set[3] && sw_clr[3] |=> event_q[3])
      else $error("coincident clear lost the event");
   a_reserved_reads_zero: assert property (ce_in && rd && offset == OFF_EVENT_SET
      |=> (rdata_out & EVENT_RSVD) == '0) else $error("reserved event bits nonzero");
   a_clear_view_and: assert property (ce_in && rd && offset == OFF_EVENT_CLR
      |=> rdata_out == $past(masked_view)) else $error("clear alias read not masked");
   a_error_summary: assert property (ce_in && |dsp_port_error_in |=> event_view[BIT_PORT_ERR_SUM])
      else $error("error summary bit not set");
   a_global_gate: assert property (ce_in && !mask_q[BIT_GLOBAL_EN] |=> !irq_out)
      else $error("interrupt raised with global enable low");
   a_irq_cause: assert property (ce_in && mask_q[BIT_GLOBAL_EN] && (event_view[0] && mask_q[0])
      |=> irq_out) else $error("enabled event did not raise interrupt");
   a_pin_gated: assert property (ce_in && !pin_cfg_in.fn_select[1] && !event_q[BIT_PIN3]
      && !sw_set[BIT_PIN3] |=> !event_q[BIT_PIN3]) else $error("pin 3 event while not selected");

   // register port, read views, mask and port control storage
   a_ack_follows_hit: assert property (ce_in && hit
      |=> ack_out)
      else $error("hitting request not acknowledged");
   a_miss_no_ack: assert property (ce_in && !hit
      |=> !ack_out)
      else $error("missed request acknowledged");
   a_set_view_raw: assert property (ce_in && rd && offset == OFF_EVENT_SET
      |=> rdata_out == $past(event_view))
      else $error("set alias read not raw");
   a_mask_view_read: assert property (ce_in && rd && (offset == OFF_MASK_SET || offset == OFF_MASK_CLR)
      |=> rdata_out == $past(mask_q))
      else $error("mask alias read wrong");
   a_mask_set_write: assert property (ce_in && wr && offset == OFF_MASK_SET && req_in.wdata[BIT_GLOBAL_EN]
      |=> mask_q[BIT_GLOBAL_EN])
      else $error("mask set write ignored");
   a_mask_clear_write: assert property (ce_in && wr && offset == OFF_MASK_CLR && req_in.wdata[BIT_GLOBAL_EN]
      |=> !mask_q[BIT_GLOBAL_EN])
      else $error("mask clear write ignored");
   a_mask_rsvd_zero: assert property ((mask_q & ~MASK_BITS) == '0)
      else $error("reserved mask bit set");
   a_dsp_reset_write: assert property (ce_in && wr && offset == OFF_DSP_RESET && req_in.wdata[0]
      |=> dsp_reset_out[0])
      else $error("reset register write ignored");
   a_width_write: assert property (ce_in && wr && offset == OFF_DATA_WIDTH && req_in.wdata[0]
      |=> port_wide_out[0])
      else $error("data width write ignored");

   // event sources and sticky storage
   a_event_rsvd_zero: assert property ((event_q & EVENT_RSVD) == '0)
      else $error("reserved event bit set");
   a_zero_clear_keeps: assert property (ce_in && wr && offset == OFF_EVENT_CLR && req_in.wdata == '0
      |=> event_q == ($past(event_q) | $past(hw_set)))
      else $error("zero clear write changed events");
   a_summary_clears: assert property (ce_in && !(|err_q) && !(|dsp_port_error_in)
      |=> !event_view[BIT_PORT_ERR_SUM])
      else $error("error summary stuck without errors");
   a_gp_int_edge: assert property (ce_in && general_interrupt_input_in && !gp_int_prev_q
      |=> event_q[BIT_GP_INT])
      else $error("general interrupt edge lost");
   a_gp_err_edge: assert property (ce_in && general_port_error_in && !gp_err_prev_q
      |=> event_q[BIT_GP_ERR])
      else $error("general port error edge lost");
   a_pin2_gated: assert property (ce_in && !pin_cfg_in.fn_select[0] && !event_q[BIT_PIN2]
      && !sw_set[BIT_PIN2] |=> !event_q[BIT_PIN2])
      else $error("pin 2 event while not selected");
   a_dsp3_edge: assert property (ce_in && dsp_channel_interrupt_in[3] && !dsp_prev_q[3]
      |=> event_q[3])
      else $error("dsp channel 3 edge lost");

endmodule : host_port_interrupt_event_csr
`default_nettype wire

// [src/hp_event_pkg.sv]
// constants and carriers for the host-port interrupt event register space
package hp_event_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int WIN_LSB = 5;
   localparam logic [4:0] OFF_EVENT_SET = 5'h00;
   localparam logic [4:0] OFF_EVENT_CLR = 5'h04;
   localparam logic [4:0] OFF_MASK_SET = 5'h08;
   localparam logic [4:0] OFF_MASK_CLR = 5'h0C;
   localparam logic [4:0] OFF_ERR_REPORT = 5'h10;
   localparam logic [4:0] OFF_DSP_RESET = 5'h14;
   localparam logic [4:0] OFF_DATA_WIDTH = 5'h18;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   localparam int BIT_GLOBAL_EN = 31;
   localparam int BIT_PORT_ERR_SUM = 30;
   localparam int BIT_GP_ERR = 29;
   localparam int BIT_PIN3 = 28;
   localparam int BIT_PIN2 = 27;
   localparam int BIT_GP_INT = 26;
   localparam int DSP_CHANNELS = 4;
   localparam logic [31:0] EVENT_SW_BITS = 32'h3C00_000F;
   localparam logic [31:0] MASK_BITS = 32'hFC00_000F;
   localparam logic [31:0] EVENT_RSVD = 32'h83FF_FFF0;
   localparam int IMPL_LSB = 8;
   localparam logic [3:0] LOW_NIBBLE = 4'hF;

   typedef struct packed {
      logic valid;
      logic write;
      logic io_space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic [1:0] fn_select;
      logic [1:0] falling;
   } pin_cfg_s;
endpackage : hp_event_pkg

// [dv/host_model.sv]
// host-side model that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model
   import hp_event_pkg::*;
(
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [DATA_W-1:0] rdata_in,
   output var reg_req_s req_out
);
   initial req_out = '0;
   // request held until ack or for at most four edges; two idle edges let a same-edge retake's ack drain first
   task automatic access(input logic wr, input logic io, input logic [ADDR_W-1:0] addr,
                         input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
      ok = 1'b0;
      rd = '0;
      repeat (2) @(posedge clk_in);
      req_out <= '{valid: 1'b1, write: wr, io_space: io, addr: addr, wdata: wd};
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk_in);
         if (ack_in === 1'b1) begin
            ok = 1'b1;
            rd = rdata_in;
         end
      end
      // released bus shows the inverse, never a stale copy
      req_out <= '{valid: 1'b0, write: ~wr, io_space: ~io, addr: ~addr, wdata: ~wd};
   endtask : access
endmodule : host_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the host-port interrupt event register space
`timescale 1ns/1ps
`default_nettype none
module testbench
   import hp_event_pkg::*;
;
   localparam logic [31:0] MB = 32'h4000_0000;
   localparam logic [31:0] IB = 32'h0000_1000;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ack, irq, ok;
   logic [31:0] rdata, rd;
   logic [3:0] dint = 4'h0, perr = 4'h0, drst, wide;
   logic gint = 1'b0, gerr = 1'b0;
   logic ce = 1'b1;
   logic [1:0] pins = 2'h0;
   pin_cfg_s cfg = '0;
   reg_req_s req;
   int n_errors = 0;
   int n_compared = 0;
   host_model u_host (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .req_out(req));
   host_port_interrupt_event_csr u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .req_in(req),
      .mem_base_in(MB), .io_base_in(IB), .dsp_channel_interrupt_in(dint), .general_interrupt_input_in(gint),
      .general_port_error_in(gerr), .gpio_pin_in(pins), .pin_cfg_in(cfg), .dsp_port_error_in(perr),
      .dsp_present_in(4'hA), .ack_out(ack), .rdata_out(rdata), .irq_out(irq), .dsp_reset_out(drst),
      .port_wide_out(wide));
   initial forever #5 clk_in = ~clk_in;
   task automatic results();
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic acc(input logic wr, input logic [4:0] off, input logic [31:0] wd, input logic io = 1'b0);
      u_host.access(wr, io, (io ? IB : MB) | {27'h0, off}, wd, rd, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[ERR] ack expected 1 seen %b", ok);
         results();
      end
   endtask : acc
   task automatic rchk(input logic [4:0] off, input logic [31:0] exp);
      acc(1'b0, off, 32'h0);
      check($sformatf("read %h", off), exp, rd);
   endtask : rchk
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
   endtask : step
   task automatic t_sw();
      rchk(OFF_EVENT_SET, 32'h0000_0000);
      rchk(OFF_MASK_SET, 32'h0000_0000);
      acc(1'b1, OFF_EVENT_SET, 32'hFFFF_FFFF);
      rchk(OFF_EVENT_SET, 32'h3C00_000F);
      acc(1'b1, OFF_EVENT_CLR, 32'h0000_0000);
      rchk(OFF_EVENT_SET, 32'h3C00_000F);
      acc(1'b1, OFF_EVENT_CLR, 32'h2400_0005);
      rchk(OFF_EVENT_SET, 32'h1800_000A);
      rchk(OFF_EVENT_CLR, 32'h0000_0000);
   endtask : t_sw
   task automatic t_mask();
      acc(1'b1, OFF_MASK_SET, 32'hFFFF_FFFF);
      rchk(OFF_MASK_CLR, 32'hFC00_000F);
      acc(1'b1, OFF_MASK_CLR, 32'h7C00_0005);
      rchk(OFF_EVENT_CLR, 32'h0000_000A);
      step(2);
      check("irq", 32'h1, {31'h0, irq});
      acc(1'b1, OFF_MASK_CLR, 32'h8000_0000);
      step(2);
      check("irq", 32'h0, {31'h0, irq});
      acc(1'b1, OFF_EVENT_CLR, 32'hFFFF_FFFF);
      rchk(OFF_EVENT_SET, 32'h0000_0000);
   endtask : t_mask
   task automatic t_hw();
      acc(1'b1, OFF_MASK_SET, 32'h8000_0001);
      @(posedge clk_in);
      dint <= 4'hF;
      gint <= 1'b1;
      gerr <= 1'b1;
      step(3);
      dint <= 4'h0;
      gint <= 1'b0;
      gerr <= 1'b0;
      step(3);
      rchk(OFF_EVENT_SET, 32'h2400_000F);
      check("irq", 32'h1, {31'h0, irq});
      acc(1'b1, OFF_EVENT_CLR, 32'hFFFF_FFFF);
      step(2);
      check("irq", 32'h0, {31'h0, irq});
      acc(1'b1, OFF_MASK_CLR, 32'hFFFF_FFFF);
   endtask : t_hw
   // the clear is taken on two edges; the dsp edge lands on the second
   task automatic t_race();
      fork
         acc(1'b1, OFF_EVENT_CLR, 32'h0000_0008);
         begin
            step(3);
            dint <= 4'h8;
         end
      join
      dint <= 4'h0;
      rchk(OFF_EVENT_SET, 32'h0000_0008);
      acc(1'b1, OFF_EVENT_CLR, 32'h0000_0008);
   endtask : t_race
   task automatic t_ce();
      @(posedge clk_in);
      ce <= 1'b0;
      dint <= 4'h1;
      step(3);
      dint <= 4'h0;
      step(3);
      ce <= 1'b1;
      rchk(OFF_EVENT_SET, 32'h0000_0000);
   endtask : t_ce
   task automatic t_pins();
      @(posedge clk_in);
      pins <= 2'h3;
      step(3);
      pins <= 2'h0;
      step(3);
      rchk(OFF_EVENT_SET, 32'h0000_0000);
      cfg <= '{fn_select: 2'h3, falling: 2'h1};
      step(3);
      pins <= 2'h3;
      step(3);
      rchk(OFF_EVENT_SET, 32'h1000_0000);
      pins <= 2'h0;
      step(3);
      rchk(OFF_EVENT_SET, 32'h1800_0000);
      acc(1'b1, OFF_EVENT_CLR, 32'hFFFF_FFFF);
   endtask : t_pins
   task automatic t_err();
      @(posedge clk_in);
      perr <= 4'h2;
      step(3);
      perr <= 4'h0;
      step(3);
      rchk(OFF_ERR_REPORT, 32'h0000_0002);
      acc(1'b1, OFF_EVENT_CLR, 32'h4000_0000);
      rchk(OFF_EVENT_SET, 32'h4000_0000);
      acc(1'b1, OFF_ERR_REPORT, 32'h0000_0002);
      rchk(OFF_EVENT_SET, 32'h0000_0000);
   endtask : t_err
   task automatic t_map();
      acc(1'b1, OFF_DSP_RESET, 32'h0000_0005, 1'b1);
      acc(1'b1, OFF_DATA_WIDTH, 32'h0000_0003, 1'b1);
      rchk(OFF_DSP_RESET, 32'h0000_0A05);
      check("reset pins", 32'h5, {28'h0, drst});
      check("width pins", 32'h3, {28'h0, wide});
      rchk(5'h1C, 32'h0000_0000);
      u_host.access(1'b0, 1'b0, 32'h5000_0000, 32'h0, rd, ok);
      check("miss ack", 32'h0, {31'h0, ok});
   endtask : t_map
   initial begin
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      t_sw();
      t_mask();
      t_hw();
      t_race();
      t_ce();
      t_pins();
      t_err();
      t_map();
      results();
   end
endmodule : testbench
`default_nettype wire
